// >>> verilog/dcld_top.sv
/*
 Dual-channel lock-in demodulator: LED modulation, NCO with digital PLL, I/Q mixing,
 boxcar FIR with decimation, magnitude by square root and phase by CORDIC.
 Assumes converter samples with a channel flag, synchronous to clk, and a plain register port.
*/
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcld_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [dcld_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dcld_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dcld_pkg::REG_W-1:0] reg_rdata,
    input wire logic adc_valid,
    input wire logic [dcld_pkg::DATA_W-1:0] adc_data,
    input wire logic adc_chan,
    output logic adc_ready,
    output logic led_mod_clk,
    output logic led_switch,
    output logic [1:0] led_colour,
    output logic [5:0] led_level,
    output logic [1:0] gain_sel,
    output logic pll_locked,
    output logic res_valid,
    output logic res_chan,
    output logic [23:0] res_i,
    output logic [23:0] res_q,
    output logic [24:0] res_mag,
    output logic [15:0] res_phase
);
    import dcld_pkg::*;

    // ==========================================
    // Sine lookup from a quarter table
    function automatic logic signed [15:0] sine_of(input logic [15:0] ph);
        logic [4:0] idx;
        logic [15:0] mag;
        idx = ph[14] ? (5'h10 - {1'b0, ph[13:10]}) : {1'b0, ph[13:10]};
        mag = SINE_Q[idx];
        return ph[15] ? -$signed(mag) : $signed(mag);
    endfunction

    // ==========================================
    // Register file
    logic run;
    logic [15:0] half_period;
    wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wire wr_half = reg_wr && (reg_addr == REG_HALF);
    wire wr_colour = reg_wr && (reg_addr == REG_COLOUR) && (reg_wdata[1:0] != COLOUR_BAD);
    wire wr_level = reg_wr && (reg_addr == REG_LEVEL);
    wire wr_gain = reg_wr && (reg_addr == REG_GAIN);
    wire [5:0] level_in = (reg_wdata > 32'(LEVEL_MAX)) ? LEVEL_MAX : reg_wdata[5:0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run <= CTRL_RST;
            half_period <= HALF_RST;
            led_colour <= COLOUR_RST;
            led_level <= LEVEL_RST;
            gain_sel <= GAIN_RST;
        end else begin
            if (wr_ctrl) run <= reg_wdata[0];
            if (wr_half) half_period <= reg_wdata[15:0];
            if (wr_colour) led_colour <= reg_wdata[1:0];
            if (wr_level) led_level <= level_in;
            if (wr_gain) gain_sel <= reg_wdata[1:0];
        end
    end

    // ==========================================
    // LED modulation clock
    logic [15:0] half_cnt;
    wire half_last = ({1'b0, half_cnt} + 17'h00001) >= {1'b0, half_period};
    wire next_mod_clk = run && (half_last ? ~led_mod_clk : led_mod_clk);
    wire mod_rise = run && half_last && !led_mod_clk;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_cnt <= 16'h0000;
            led_mod_clk <= 1'b0;
            led_switch <= 1'b0;
        end else begin
            half_cnt <= (!run || half_last) ? 16'h0000 : half_cnt + 16'h0001;
            led_mod_clk <= next_mod_clk;
            led_switch <= next_mod_clk;
        end
    end

    // ==========================================
    // NCO with proportional-integral phase lock
    logic [31:0] nco_phase;
    logic [31:0] nco_inc;
    wire signed [31:0] pll_err = $signed(nco_phase);
    wire [31:0] err_p = 32'(pll_err >>> DPLL_KP);
    // Integral path scaled down so the loop stays stable at the longest LED period
    localparam int KI_SHIFT = DPLL_KI + 10;
    wire [31:0] err_i = 32'(pll_err >>> KI_SHIFT);
    // Seed of one NCO turn per LED period; a zero increment would read as locked
    wire [15:0] half_eff = (half_period == 16'h0000) ? 16'h0001 : half_period;
    wire [31:0] inc_seed = 32'h80000000 / {16'h0000, half_eff};
    wire [15:0] err_hi = pll_err[31] ? (16'h0000 - nco_phase[31:16]) : nco_phase[31:16];
    wire signed [15:0] sin_val = sine_of(nco_phase[31:16]);
    wire signed [15:0] cos_val = sine_of(nco_phase[31:16] + PHASE_QUARTER);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nco_phase <= 32'h00000000;
            nco_inc <= NCO_INC_RST;
            pll_locked <= 1'b0;
        end else if (!run) begin
            nco_phase <= 32'h00000000;
            nco_inc <= inc_seed;
            pll_locked <= 1'b0;
        end else if (mod_rise) begin
            nco_phase <= nco_phase + nco_inc - err_p;
            nco_inc <= nco_inc - err_i;
            pll_locked <= err_hi < LOCK_TOL;
        end else begin
            nco_phase <= nco_phase + nco_inc;
        end
    end

    // ==========================================
    // Two-entry input buffer
    logic [24:0] buf_mem [0:1];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    dcld_pp_t pp_state;
    wire mac_ready = (pp_state == PP_IDLE);
    wire buf_valid = (buf_cnt != 2'h0);
    wire push = adc_valid && adc_ready;
    wire pop = buf_valid && mac_ready;
    wire [1:0] next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
    wire [24:0] head = buf_mem[buf_rp];
    wire head_ch = head[24];
    wire signed [23:0] head_data = $signed(head[23:0]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            adc_ready <= 1'b0;
            buf_mem[0] <= 25'h0000000;
            buf_mem[1] <= 25'h0000000;
        end else begin
            if (push) buf_mem[buf_wp] <= {adc_chan, adc_data};
            if (push) buf_wp <= ~buf_wp;
            if (pop) buf_rp <= ~buf_rp;
            buf_cnt <= next_buf_cnt;
            adc_ready <= (next_buf_cnt != 2'h2);
        end
    end

    // ==========================================
    // Mixers and per-channel boxcar FIR with decimation
    wire signed [39:0] prod_i = head_data * sin_val;
    wire signed [39:0] prod_q = head_data * cos_val;
    wire [31:0] mix_i = {{8{prod_i[38]}}, prod_i[38:15]};
    wire [31:0] mix_q = {{8{prod_q[38]}}, prod_q[38:15]};
    logic [31:0] acc_i [0:1];
    logic [31:0] acc_q [0:1];
    logic [7:0] fir_cnt [0:1];
    wire [1:0] dump;
    wire pp_start = |dump;
    wire dump_ch = dump[1];
    wire [31:0] sum_i = acc_i[dump_ch] + mix_i;
    wire [31:0] sum_q = acc_q[dump_ch] + mix_q;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            assign dump[c] = pop && (head_ch == 1'(c)) && (fir_cnt[c] == FIR_LAST);
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    acc_i[c] <= 32'h00000000;
                    acc_q[c] <= 32'h00000000;
                    fir_cnt[c] <= 8'h00;
                end else if (dump[c]) begin
                    acc_i[c] <= 32'h00000000;
                    acc_q[c] <= 32'h00000000;
                    fir_cnt[c] <= 8'h00;
                end else if (pop && (head_ch == 1'(c))) begin
                    acc_i[c] <= acc_i[c] + mix_i;
                    acc_q[c] <= acc_q[c] + mix_q;
                    fir_cnt[c] <= fir_cnt[c] + 8'h01;
                end
            end
        end
    endgenerate

    // ==========================================
    // Post-processing: square root and CORDIC vectoring
    wire signed [23:0] fir_i = $signed(sum_i[31:8]);
    wire signed [23:0] fir_q = $signed(sum_q[31:8]);
    wire [49:0] radicand = 50'(48'(fir_i * fir_i)) + 50'(48'(fir_q * fir_q));
    logic [23:0] lat_i;
    logic [23:0] lat_q;
    logic lat_ch;
    logic [4:0] step;
    logic [49:0] rad;
    logic [27:0] rem;
    logic [24:0] root;
    logic signed [25:0] cx;
    logic signed [25:0] cy;
    logic [15:0] cz;
    wire [27:0] rem_sh = {rem[25:0], rad[49:48]};
    wire [27:0] trial = {1'b0, root, 2'b01};
    wire root_bit = rem_sh >= trial;
    wire signed [25:0] cx_sh = cx >>> step;
    wire signed [25:0] cy_sh = cy >>> step;
    wire cordic_on = step < CORDIC_STEPS;
    wire [15:0] atan_k = ATAN_T[step[3:0]];
    wire neg_i = fir_i[23];
    wire signed [25:0] ext_i = 26'(fir_i);
    wire signed [25:0] ext_q = 26'(fir_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pp_state <= PP_IDLE;
            step <= 5'h00;
            rad <= 50'h0;
            rem <= 28'h0;
            root <= 25'h0;
            cx <= 26'sh0;
            cy <= 26'sh0;
            cz <= 16'h0000;
            lat_i <= 24'h000000;
            lat_q <= 24'h000000;
            lat_ch <= 1'b0;
        end else begin
            case (pp_state)
                PP_IDLE: begin
                    if (pp_start) begin
                        pp_state <= PP_CALC;
                        step <= 5'h00;
                        rad <= radicand;
                        rem <= 28'h0;
                        root <= 25'h0;
                        cx <= neg_i ? -ext_i : ext_i;
                        cy <= neg_i ? -ext_q : ext_q;
                        cz <= neg_i ? PHASE_HALF : 16'h0000;
                        lat_i <= fir_i;
                        lat_q <= fir_q;
                        lat_ch <= dump_ch;
                    end
                end
                PP_CALC: begin
                    rad <= {rad[47:0], 2'b00};
                    rem <= root_bit ? rem_sh - trial : rem_sh;
                    root <= {root[23:0], root_bit};
                    if (cordic_on) begin
                        cx <= cy[25] ? cx - cy_sh : cx + cy_sh;
                        cy <= cy[25] ? cy + cx_sh : cy - cx_sh;
                        cz <= cy[25] ? cz - atan_k : cz + atan_k;
                    end
                    step <= step + 5'h01;
                    if (step == SQRT_LAST) pp_state <= PP_DONE;
                end
                PP_DONE: pp_state <= PP_IDLE;
                default: pp_state <= PP_IDLE;
            endcase
        end
    end

    // ==========================================
    // Result outputs and per-channel result store
    logic [23:0] st_i [0:1];
    logic [23:0] st_q [0:1];
    logic [24:0] st_mag [0:1];
    logic [15:0] st_ph [0:1];
    wire pp_done = (pp_state == PP_DONE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            res_valid <= 1'b0;
            res_chan <= 1'b0;
            res_i <= 24'h000000;
            res_q <= 24'h000000;
            res_mag <= 25'h0000000;
            res_phase <= 16'h0000;
            st_i <= '{24'h000000, 24'h000000};
            st_q <= '{24'h000000, 24'h000000};
            st_mag <= '{25'h0000000, 25'h0000000};
            st_ph <= '{16'h0000, 16'h0000};
        end else begin
            res_valid <= pp_done;
            if (pp_done) begin
                res_chan <= lat_ch;
                res_i <= lat_i;
                res_q <= lat_q;
                res_mag <= root;
                res_phase <= cz;
                st_i[lat_ch] <= lat_i;
                st_q[lat_ch] <= lat_q;
                st_mag[lat_ch] <= root;
                st_ph[lat_ch] <= cz;
            end
        end
    end

    // ==========================================
    // Read port
    wire res_sel = (reg_addr >= REG_RES1);
    wire [3:0] res_base = res_sel ? REG_RES1 : REG_RES0;
    wire [3:0] res_off = reg_addr - res_base;
    wire res_hit = (reg_addr >= REG_RES0) && (reg_addr < (REG_RES1 + 4'h4));
    logic [31:0] res_word;
    always_comb begin
        case (res_off[1:0])
            2'h0: res_word = {{8{st_i[res_sel][23]}}, st_i[res_sel]};
            2'h1: res_word = {{8{st_q[res_sel][23]}}, st_q[res_sel]};
            2'h2: res_word = {7'h00, st_mag[res_sel]};
            default: res_word = {16'h0000, st_ph[res_sel]};
        endcase
    end
    wire [31:0] rd_mux =
        (reg_addr == REG_CTRL) ? {31'h0, run} :
        (reg_addr == REG_HALF) ? {16'h0000, half_period} :
        (reg_addr == REG_COLOUR) ? {30'h0, led_colour} :
        (reg_addr == REG_LEVEL) ? {26'h0, led_level} :
        (reg_addr == REG_GAIN) ? {30'h0, gain_sel} :
        (reg_addr == REG_STATUS) ? {29'h0, mac_ready, run, pll_locked} :
        res_hit ? res_word : 32'h00000000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) reg_rdata <= 32'h00000000;
        else reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_dump_start;
        (pp_state == PP_IDLE) && pp_start;
    endsequence
    sequence s_result_out;
        res_valid && (res_chan == $past(lat_ch));
    endsequence

    property p_led_drive;
        led_switch == (led_mod_clk && $past(run));
    endproperty
    a_led_drive: assert property (p_led_drive) else $error("LED drive not following clock");

    property p_mod_toggle;
        run && $past(run) && half_last && $past(half_period) == half_period
            |=> $changed(led_mod_clk);
    endproperty
    a_mod_toggle: assert property (p_mod_toggle) else $error("LED clock missed toggle");

    property p_pll_lock;
        run && mod_rise && (err_hi >= LOCK_TOL) |=> !pll_locked;
    endproperty
    a_pll_lock: assert property (p_pll_lock) else $error("Lock flag with large error");

    property p_colour;
        led_colour != COLOUR_BAD;
    endproperty
    a_colour: assert property (p_colour) else $error("Invalid colour code");

    property p_level;
        wr_level |=> (led_level <= LEVEL_MAX) && (led_level == $past(level_in));
    endproperty
    a_level: assert property (p_level) else $error("LED level out of range");

    property p_gain;
        wr_gain |=> gain_sel == $past(reg_wdata[1:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("Gain select not updated");

    property p_route;
        pop && !head_ch && !dump[0] |=> fir_cnt[0] == $past(fir_cnt[0]) + 8'h01
            && fir_cnt[1] == $past(fir_cnt[1]);
    endproperty
    a_route: assert property (p_route) else $error("Sample routed to wrong channel");

    property p_result_time;
        s_dump_start ##1 (pp_state == PP_CALC) [*8] |-> ##19 s_result_out;
    endproperty
    a_result_time: assert property (p_result_time) else $error("Result strobe late");

    property p_magnitude;
        res_valid |-> 52'(res_mag) * 52'(res_mag) <= 52'(48'($signed(res_i) * $signed(res_i)))
            + 52'(48'($signed(res_q) * $signed(res_q)));
    endproperty
    a_magnitude: assert property (p_magnitude) else $error("Magnitude too large");

    property p_phase_quadrant;
        res_valid && !res_i[23] && !res_q[23] |-> res_phase <= PHASE_QUARTER + 16'h0010;
    endproperty
    a_phase_quadrant: assert property (p_phase_quadrant) else $error("Phase quadrant wrong");

    property p_buffer_full;
        buf_cnt == 2'h2 |-> !adc_ready;
    endproperty
    a_buffer_full: assert property (p_buffer_full) else $error("Ready while buffer full");

    property p_read_once;
        !$past(reg_rd) |-> reg_rdata == 32'h00000000;
    endproperty
    a_read_once: assert property (p_read_once) else $error("Read data outside slot");
endmodule // dcld_top
`default_nettype wire

// >>> verilog/dcld_pkg.sv
/*
 Constants, register map, tables and types of the dual-channel lock-in demodulator.
 Assumes a single 10 MHz system clock; offsets are word indices on the plain register port.
*/
package dcld_pkg;
    // ==========================================
    // Widths
    localparam int ADDR_W = 4;
    localparam int REG_W = 32;
    localparam int DATA_W = 24;
    // ==========================================
    // Register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_HALF = 4'h1;
    localparam logic [3:0] REG_COLOUR = 4'h2;
    localparam logic [3:0] REG_LEVEL = 4'h3;
    localparam logic [3:0] REG_GAIN = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_RES0 = 4'h6;
    localparam logic [3:0] REG_RES1 = 4'hA;
    // ==========================================
    // Reset values and limits
    localparam logic CTRL_RST = 1'b0;
    localparam logic [15:0] HALF_RST = 16'h1326;
    localparam logic [1:0] COLOUR_RST = 2'h0;
    localparam logic [1:0] COLOUR_BAD = 2'h3;
    localparam logic [5:0] LEVEL_RST = 6'h00;
    localparam logic [5:0] LEVEL_MAX = 6'h20;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [31:0] NCO_INC_RST = 32'h00000000;
    // ==========================================
    // Loop, filter and arithmetic counts
    localparam int DPLL_KP = 2;
    localparam int DPLL_KI = 6;
    localparam logic [15:0] LOCK_TOL = 16'h0200;
    localparam logic [7:0] FIR_LAST = 8'hFF;
    localparam logic [4:0] SQRT_LAST = 5'h18;
    localparam logic [4:0] CORDIC_STEPS = 5'h0C;
    localparam logic [15:0] PHASE_HALF = 16'h8000;
    localparam logic [15:0] PHASE_QUARTER = 16'h4000;
    // ==========================================
    // Quarter-wave sine, full scale 0x7FFF
    localparam logic [15:0] SINE_Q [0:16] = '{
        16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56, 16'h471C, 16'h5133,
        16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2, 16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61,
        16'h7FFF};
    // Arctangent of 2^-k, 0x10000 per turn
    localparam logic [15:0] ATAN_T [0:11] = '{
        16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146, 16'h00A3, 16'h0051,
        16'h0029, 16'h0014, 16'h000A, 16'h0005};
    // ==========================================
    typedef enum {PP_IDLE, PP_CALC, PP_DONE} dcld_pp_t;
endpackage

// >>> tb/dcld_front_model.sv
/*
 Front-end model: converter offering two-channel samples on a valid/ready stream.
 Assumes the design's stream port on one clock; the offer is held until taken.
*/
`timescale 1ns/1ps
`default_nettype none
module dcld_front_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic slow,
    input wire logic [23:0] amp0,
    input wire logic [23:0] amp1,
    input wire logic adc_ready,
    output logic adc_valid,
    output logic [23:0] adc_data,
    output logic adc_chan
);
    logic [5:0] gap;
    // ========================================
    // Sample offer; idle data keeps changing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adc_valid <= 1'b0;
            adc_chan <= 1'b1;
            adc_data <= 24'h000000;
            gap <= 6'h00;
        end else if (adc_valid) begin
            if (adc_ready) begin
                adc_valid <= 1'b0;
                adc_data <= ~adc_data;
                gap <= slow ? 6'h26 : 6'h00;
            end
        end else if (en && gap == 6'h00) begin
            adc_valid <= 1'b1;
            adc_chan <= ~adc_chan;
            adc_data <= adc_chan ? amp0 : amp1;
        end else begin
            adc_data <= ~adc_data;
            gap <= (gap != 6'h00) ? gap - 6'h01 : gap;
        end
    end
endmodule // dcld_front_model
`default_nettype wire

// >>> tb/test_dcld_top.sv
/*
 Self-checking bench for the lock-in demodulator: registers, LED clock, PLL, I/Q results.
 Assumes dcld_pkg and the front-end model; one 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dcld_top;
    import dcld_pkg::*;
    logic clk, nrst, reg_wr, reg_rd, adc_valid, adc_chan, adc_ready, en, slow, watch, saw_full;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [23:0] adc_data, amp0, amp1, res_i, res_q;
    logic led_mod_clk, led_switch, pll_locked, res_valid, res_chan;
    logic [1:0] led_colour, gain_sel;
    logic [5:0] led_level;
    logic [24:0] res_mag;
    logic [15:0] res_phase;
    int error_cnt, n_tests, k;
    // Rows: address, write data, read back, {colour, level, gain}
    logic [77:0] rows [12] = '{
        {REG_HALF, 32'h10, 32'h10, 10'h000}, {REG_COLOUR, 32'h1, 32'h1, 10'h100},
        {REG_COLOUR, 32'h3, 32'h1, 10'h100}, {REG_COLOUR, 32'h2, 32'h2, 10'h200},
        {REG_LEVEL, 32'h20, 32'h20, 10'h280}, {REG_LEVEL, 32'h3F, 32'h20, 10'h280},
        {REG_LEVEL, 32'h5, 32'h5, 10'h214}, {REG_GAIN, 32'h1, 32'h1, 10'h215},
        {REG_GAIN, 32'h2, 32'h2, 10'h216}, {REG_STATUS, 32'hFF, 32'h4, 10'h216},
        {4'hE, 32'h1234, 32'h0, 10'h216}, {REG_COLOUR, 32'h0, 32'h0, 10'h016}};
    logic [31:0] exp_r [6] = '{32'h0, 32'h0000FFFE, 32'h0000FFFE,
        32'h0, 32'hFFFF8001, 32'h00007FFF};
    dcld_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
        .adc_data(adc_data), .adc_chan(adc_chan), .adc_ready(adc_ready),
        .led_mod_clk(led_mod_clk), .led_switch(led_switch), .led_colour(led_colour),
        .led_level(led_level), .gain_sel(gain_sel), .pll_locked(pll_locked),
        .res_valid(res_valid), .res_chan(res_chan), .res_i(res_i), .res_q(res_q),
        .res_mag(res_mag), .res_phase(res_phase));
    dcld_front_model u_front (.clk(clk), .nrst(nrst), .en(en), .slow(slow), .amp0(amp0),
        .amp1(amp1), .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_data(adc_data),
        .adc_chan(adc_chan));
    // ========================================
    // Helpers
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic tick_until_bound(input int bound);
        if (k >= bound) begin
            error_cnt++;
            end_of_test();
        end
        @(posedge clk);
        #1;
        k++;
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rst_pins", {led_colour, led_level, gain_sel, led_mod_clk, led_switch,
            res_valid, adc_ready}, 32'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("adc_ready", adc_ready, 1'b1);
        rd(REG_HALF, d);
        chk("half_rst", d, {16'h0, HALF_RST});
    endtask
    task automatic wait_res(input logic ch, input logic [23:0] q, input logic [24:0] m,
        input logic [15:0] ph);
        k = 0;
        while (res_valid !== 1'b1) tick_until_bound(4000);
        chk("res_chan", res_chan, ch);
        chk("res_i", res_i, 24'h0);
        chk("res_q", res_q, q);
        chk("res_mag", res_mag, m);
        chk("res_phase", 16'(res_phase - ph + 16'h0010) <= 16'h0020, 1'b1);
        @(posedge clk);
        #1;
        chk("res_pulse", res_valid, 1'b0);
    endtask
    always @(posedge clk) if (watch && adc_ready === 1'b0) saw_full <= 1'b1;
    // ========================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {nrst, reg_wr, reg_rd, en, watch, saw_full} = 6'h00;
        {reg_addr, reg_wdata} = 36'h0;
        slow = 1'b1;
        amp0 = 24'h010000;
        amp1 = 24'hFF8000;
        do_reset();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            wr(rows[i][77:74], rows[i][73:42]);
            rd(rows[i][77:74], d);
            chk("reg", d, rows[i][41:10]);
            chk("pins", {led_colour, led_level, gain_sel}, rows[i][9:0]);
        end
        $display("test registers done");
        wr(REG_HALF, 32'h5);
        wr(REG_CTRL, 32'h1);
        en <= 1'b1;
        #1;
        k = 0;
        while (led_mod_clk !== 1'b1) tick_until_bound(100);
        k = 0;
        while (led_mod_clk === 1'b1) begin
            chk("led_switch", led_switch, 1'b1);
            tick_until_bound(100);
        end
        chk("half_len", k, 5);
        rd(REG_STATUS, d);
        chk("run", d[1], 1'b1);
        k = 0;
        while (pll_locked !== 1'b1) tick_until_bound(40000);
        chk("locked", pll_locked, 1'b1);
        $display("test led clock done");
        slow <= 1'b0;
        do_reset();
        watch <= 1'b1;
        wait_res(1'b0, 24'h00FFFE, 25'h00FFFE, 16'h4000);
        wait_res(1'b1, 24'hFF8001, 25'h007FFF, 16'hC000);
        en <= 1'b0;
        chk("buffer_full", saw_full, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rd((i < 3) ? 4'(6 + i) : 4'(7 + i), d);
            chk("res_reg", d, exp_r[i]);
        end
        $display("test demodulation done");
        end_of_test();
    end
endmodule // test_dcld_top
`default_nettype wire
